/* File: rtl/tu_adapt_defs.vh */
`ifndef TU_ADAPT_DEFS_VH
`define TU_ADAPT_DEFS_VH

// Register byte offsets on the AXI4-Lite slave.
`define REG_CTRL_OFS       8'h00
`define REG_STATUS_OFS     8'h04
`define REG_JUST_CNT_OFS   8'h08

// Control register fields and reset value.
`define CTRL_TU2_BIT       0
`define CTRL_L_LSB         8
`define CTRL_L_MSB         12
`define CTRL_M_LSB         16
`define CTRL_M_MSB         17
`define CTRL_SSF_EN_BIT    20
`define CTRL_RESET         32'h00110101

// Status register fields.
`define STAT_PTR_LSB       0
`define STAT_FILL_LSB      16
`define STAT_EMPTY_BIT     24
`define STAT_ALARM_BIT     25
`define STAT_PHASE_LSB     26

// AXI responses.
`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2

// Timeslot layout of the access point.
`define SLOT_LAST          7'h3B
`define L_MAX              5'h14
`define M_MAX              2'h3

// Multiframe phase codes of the V1 to V4 frames.
`define PH_V1              2'h3
`define PH_V2              2'h0
`define PH_V3              2'h1
`define PH_V4              2'h2

// Size indicator and new data flag codes.
`define SS_TU2             2'h0
`define SS_TU12            2'h2
`define NDF_NORMAL         4'h6
`define NDF_NEW            4'h9

// Pointer ranges and the bits inverted on a justification.
`define TU2_PTR_MAX        10'h1AB
`define TU12_PTR_MAX       10'h08B
`define PTR_I_MASK         10'h2AA
`define PTR_D_MASK         10'h155

// Justification decisions.
`define JUST_NONE          2'h0
`define JUST_POS           2'h1
`define JUST_NEG           2'h2

`endif

/* File: rtl/tu_elastic_store.v */
`timescale 1ns/1ps
`default_nettype none

module tu_elastic_store
#(
  parameter WIDTH  = 9,
  parameter ADDR_W = 4
)
(
  input  wire              sys_clk,
  input  wire              sys_rst,
  input  wire              wr_en,
  input  wire [WIDTH-1:0]  wr_data,
  input  wire              rd_en,
  output wire [WIDTH-1:0]  rd_data,
  output wire [ADDR_W:0]   fill,
  output wire              full,
  output wire              empty
);

  reg [WIDTH-1:0]  mem [0:(1<<ADDR_W)-1];
  reg [ADDR_W:0]   wr_ptr_reg;
  reg [ADDR_W:0]   rd_ptr_reg;

  assign fill    = wr_ptr_reg - rd_ptr_reg;
  assign full    = (fill[ADDR_W] == 1'b1);
  assign empty   = (wr_ptr_reg == rd_ptr_reg);
  assign rd_data = mem[rd_ptr_reg[ADDR_W-1:0]];

  always @(posedge sys_clk)
  begin
    if (wr_en && !full)
    begin
      mem[wr_ptr_reg[ADDR_W-1:0]] <= wr_data;
    end
  end

  always @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      wr_ptr_reg <= {(ADDR_W+1){1'b0}};
      rd_ptr_reg <= {(ADDR_W+1){1'b0}};
    end
    else
    begin
      if (wr_en && !full)
      begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (rd_en && !empty)
      begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
    end
  end

endmodule // tu_elastic_store

`default_nettype wire

/* File: rtl/tu_pointer_adaptation_source.v */
`timescale 1ns/1ps
`default_nettype none
`include "tu_adapt_defs.vh"

module tu_pointer_adaptation_source
#(
  parameter ADDR_W    = 4,
  parameter FILL_LOW  = 4,
  parameter FILL_HIGH = 12
)
(
  input  wire        sys_clk,
  input  wire        sys_rst,
  input  wire [7:0]  tributary_data_in,
  input  wire        tributary_clock_in,
  input  wire        tributary_frame_start_in,
  input  wire        server_fail_in,
  input  wire        aggregate_clock_in,
  input  wire        aggregate_frame_start_in,
  input  wire        aggregate_multiframe_start_in,
  input  wire        activate_ctrl,
  output wire [7:0]  group_access_data_out,
  output wire        group_access_data_oe,
  output wire        group_access_clock_out,
  output wire        group_access_frame_start_out,
  input  wire [7:0]  awaddr,
  input  wire        awvalid,
  output wire        awready,
  input  wire [31:0] wdata,
  input  wire [3:0]  wstrb,
  input  wire        wvalid,
  output wire        wready,
  output wire [1:0]  bresp,
  output wire        bvalid,
  input  wire        bready,
  input  wire [7:0]  araddr,
  input  wire        arvalid,
  output wire        arready,
  output wire [31:0] rdata,
  output wire [1:0]  rresp,
  output wire        rvalid,
  input  wire        rready
);

  // Every input outside the AXI port passes two flip-flops; clocks get a third for edges.
  wire [14:0] pins = {tributary_data_in, tributary_frame_start_in,
                      tributary_clock_in, aggregate_clock_in,
                      aggregate_frame_start_in,
                      aggregate_multiframe_start_in, server_fail_in,
                      activate_ctrl};
  reg  [14:0] meta_reg;
  reg  [14:0] sync_reg;
  reg         trib_ck_d_reg;
  reg         agg_ck_d_reg;

  wire [7:0] trib_data = sync_reg[14:7];
  wire       trib_fs   = sync_reg[6];
  wire       trib_ck   = sync_reg[5];
  wire       agg_ck    = sync_reg[4];
  wire       agg_fs    = sync_reg[3];
  wire       agg_mfs   = sync_reg[2];
  wire       ssf       = sync_reg[1];
  wire       active    = sync_reg[0];
  wire       trib_edge = trib_ck && !trib_ck_d_reg;
  wire       agg_edge  = agg_ck && !agg_ck_d_reg;

  reg  [31:0] ctrl_reg;
  wire        tu2_mode = ctrl_reg[`CTRL_TU2_BIT];
  wire [4:0]  l_sel    = ctrl_reg[`CTRL_L_MSB:`CTRL_L_LSB];
  wire [1:0]  m_sel    = ctrl_reg[`CTRL_M_MSB:`CTRL_M_LSB];
  wire        ssf_en   = ctrl_reg[`CTRL_SSF_EN_BIT];

  reg  [6:0]  slot_reg;
  reg  [1:0]  phase_reg;
  reg         vdone_reg;
  reg         v3seen_reg;
  reg  [1:0]  just_reg;
  reg  [9:0]  ptr_reg;
  reg  [9:0]  word_reg;
  reg  [9:0]  new_ptr_reg;
  reg         ndf_pend_reg;
  reg  [9:0]  pay_cnt_reg;
  reg  [15:0] pos_cnt_reg;
  reg  [15:0] neg_cnt_reg;
  reg         alarm_insert_action;
  reg  [7:0]  data_out_reg;
  reg         oe_reg;
  reg         clk_out_reg;
  reg         fs_out_reg;

  wire [8:0]        rd_data;
  wire [ADDR_W:0]   fill;
  wire              empty;

  // Position of the byte that arrives with this aggregate clock edge.
  reg  [6:0]  slot_now;
  reg  [1:0]  multiframe_phase_code;
  reg         vdone_prev;
  reg         v3seen_prev;
  always @*
  begin
    slot_now              = (slot_reg == `SLOT_LAST) ? 7'h00
                            : slot_reg + 7'h01;
    multiframe_phase_code = phase_reg;
    vdone_prev            = vdone_reg;
    v3seen_prev           = v3seen_reg;
    if (agg_fs)
    begin
      slot_now              = 7'h00;
      multiframe_phase_code = agg_mfs ? `PH_V1 : phase_reg + 2'h1;
      vdone_prev            = 1'b0;
      v3seen_prev           = 1'b0;
    end
  end

  wire [6:0] l_base = {2'h0, l_sel} - 7'h01;
  wire [6:0] base3  = {l_base[5:0], 1'b0} + l_base;
  wire [6:0] tu12_s = base3 + {5'h00, m_sel} - 7'h01;
  wire       l_ok   = (l_sel != 5'h00) && (l_sel <= `L_MAX);
  wire       m_ok   = (m_sel != 2'h0) && (m_sel <= `M_MAX);
  wire       hit2   = (slot_now >= base3) && (slot_now < base3 + 7'h03);
  wire       hit    = tu2_mode ? (l_ok && hit2)
                      : (l_ok && m_ok && slot_now == tu12_s);
  wire       owned  = active && hit;
  wire       is_v   = owned && !vdone_prev;
  wire       is_v3p1 = owned && vdone_prev && !v3seen_prev
                       && multiframe_phase_code == `PH_V3;
  wire [9:0] ptr_max = tu2_mode ? `TU2_PTR_MAX : `TU12_PTR_MAX;
  wire [1:0] ss_code = tu2_mode ? `SS_TU2 : `SS_TU12;

  // Justification decision taken at V1 from the store fill.
  reg  [1:0] v1_just;
  reg  [9:0] v1_word;
  reg  [3:0] v1_ndf;
  always @*
  begin
    v1_just = `JUST_NONE;
    v1_word = ptr_reg;
    v1_ndf  = `NDF_NORMAL;
    if (ndf_pend_reg)
    begin
      v1_word = new_ptr_reg;
      v1_ndf  = `NDF_NEW;
    end
    else if (fill < FILL_LOW)
    begin
      v1_just = `JUST_POS;
      v1_word = ptr_reg ^ `PTR_I_MASK;
    end
    else if (fill > FILL_HIGH)
    begin
      v1_just = `JUST_NEG;
      v1_word = ptr_reg ^ `PTR_D_MASK;
    end
  end

  wire is_payload = owned && !is_v;
  wire skip_rd    = is_v3p1 && just_reg == `JUST_POS;
  wire extra_rd   = is_v && multiframe_phase_code == `PH_V3
                    && just_reg == `JUST_NEG;
  wire rd_en      = agg_edge && !empty
                    && ((is_payload && !skip_rd) || extra_rd);

  tu_elastic_store
  #(
    .WIDTH  (9),
    .ADDR_W (ADDR_W)
  )
  u_store
  (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .wr_en   (trib_edge),
    .wr_data ({trib_fs, trib_data}),
    .rd_en   (rd_en),
    .rd_data (rd_data),
    .fill    (fill),
    .full    (),
    .empty   (empty)
  );

  always @(posedge sys_clk)
  begin
    meta_reg <= pins;
    if (sys_rst)
    begin
      sync_reg      <= 15'h0000;
      trib_ck_d_reg <= 1'b0;
      agg_ck_d_reg  <= 1'b0;
    end
    else
    begin
      sync_reg      <= meta_reg;
      trib_ck_d_reg <= trib_ck;
      agg_ck_d_reg  <= agg_ck;
    end
  end

  always @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      slot_reg            <= `SLOT_LAST;
      phase_reg           <= `PH_V4;
      vdone_reg           <= 1'b0;
      v3seen_reg          <= 1'b0;
      just_reg            <= `JUST_NONE;
      ptr_reg             <= 10'h000;
      word_reg            <= 10'h000;
      new_ptr_reg         <= 10'h000;
      ndf_pend_reg        <= 1'b0;
      pay_cnt_reg         <= 10'h000;
      pos_cnt_reg         <= 16'h0000;
      neg_cnt_reg         <= 16'h0000;
      alarm_insert_action <= 1'b0;
      data_out_reg        <= 8'h00;
      oe_reg              <= 1'b0;
      clk_out_reg         <= 1'b0;
      fs_out_reg          <= 1'b0;
    end
    else
    begin
      // Disabling the enable bit makes an open input count as false.
      alarm_insert_action <= ssf && ssf_en;
      // Output clock rises mid byte, so the far end samples stable data.
      clk_out_reg <= active && !agg_ck;
      // Deactivation releases the access point at once, not at the next slot.
      if (!active)
      begin
        oe_reg       <= 1'b0;
        fs_out_reg   <= 1'b0;
        data_out_reg <= 8'h00;
      end
      if (agg_edge)
      begin
        slot_reg   <= slot_now;
        phase_reg  <= multiframe_phase_code;
        vdone_reg  <= vdone_prev || owned;
        v3seen_reg <= v3seen_prev
                      || (owned && multiframe_phase_code == `PH_V3);
        fs_out_reg <= active && agg_fs;
        oe_reg     <= owned;
        data_out_reg <= 8'h00;
        if (is_v)
        begin
          case (multiframe_phase_code)
            `PH_V1:
            begin
              just_reg     <= v1_just;
              word_reg     <= v1_word;
              ndf_pend_reg <= 1'b0;
              if (ndf_pend_reg)
              begin
                ptr_reg <= new_ptr_reg;
              end
              data_out_reg <= {v1_ndf, ss_code, v1_word[9:8]};
            end
            `PH_V2:
            begin
              data_out_reg <= word_reg[7:0];
              pay_cnt_reg  <= 10'h000;
              if (just_reg == `JUST_POS)
              begin
                ptr_reg     <= (ptr_reg == ptr_max) ? 10'h000
                               : ptr_reg + 10'h001;
                pos_cnt_reg <= pos_cnt_reg + 16'h0001;
              end
              else if (just_reg == `JUST_NEG)
              begin
                ptr_reg     <= (ptr_reg == 10'h000) ? ptr_max
                               : ptr_reg - 10'h001;
                neg_cnt_reg <= neg_cnt_reg + 16'h0001;
              end
            end
            `PH_V3:
            begin
              if (extra_rd)
              begin
                data_out_reg <= rd_data[7:0];
              end
            end
            default:
            begin
              data_out_reg <= 8'h00;
            end
          endcase
        end
        else if (is_payload && !skip_rd && !empty)
        begin
          data_out_reg <= rd_data[7:0];
        end
        if ((is_payload || extra_rd) && pay_cnt_reg < ptr_max)
        begin
          pay_cnt_reg <= pay_cnt_reg + 10'h001;
        end
        // A frame marker away from the pointed byte re-aligns the pointer.
        if (rd_en && rd_data[8] && just_reg == `JUST_NONE
            && pay_cnt_reg != ptr_reg)
        begin
          new_ptr_reg  <= pay_cnt_reg;
          ndf_pend_reg <= 1'b1;
        end
        if (owned && alarm_insert_action)
        begin
          data_out_reg <= 8'hFF;
        end
      end
    end
  end

  // AXI4-Lite slave: address and data are taken in either order.
  reg        awready_reg;
  reg        wready_reg;
  reg        bvalid_reg;
  reg [1:0]  bresp_reg;
  reg [7:0]  waddr_reg;
  reg [31:0] wdata_reg;
  reg [3:0]  wstrb_reg;
  reg        arready_reg;
  reg        rvalid_reg;
  reg [1:0]  rresp_reg;
  reg [31:0] rdata_reg;
  wire       aw_held = !awready_reg;
  wire       w_held  = !wready_reg;

  always @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      ctrl_reg    <= `CTRL_RESET;
      awready_reg <= 1'b1;
      wready_reg  <= 1'b1;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= `RESP_OKAY;
      waddr_reg   <= 8'h00;
      wdata_reg   <= 32'h00000000;
      wstrb_reg   <= 4'h0;
      arready_reg <= 1'b1;
      rvalid_reg  <= 1'b0;
      rresp_reg   <= `RESP_OKAY;
      rdata_reg   <= 32'h00000000;
    end
    else
    begin
      if (awvalid && awready_reg)
      begin
        waddr_reg   <= awaddr;
        awready_reg <= 1'b0;
      end
      if (wvalid && wready_reg)
      begin
        wdata_reg  <= wdata;
        wstrb_reg  <= wstrb;
        wready_reg <= 1'b0;
      end
      if (aw_held && w_held && !bvalid_reg)
      begin
        bvalid_reg <= 1'b1;
        bresp_reg  <= `RESP_SLVERR;
        if (waddr_reg[7:2] == `REG_CTRL_OFS >> 2)
        begin
          bresp_reg <= `RESP_OKAY;
          if (wstrb_reg[0]) ctrl_reg[7:0]   <= wdata_reg[7:0];
          if (wstrb_reg[1]) ctrl_reg[15:8]  <= wdata_reg[15:8];
          if (wstrb_reg[2]) ctrl_reg[23:16] <= wdata_reg[23:16];
          if (wstrb_reg[3]) ctrl_reg[31:24] <= wdata_reg[31:24];
        end
        else if (waddr_reg[7:2] == `REG_STATUS_OFS >> 2
                 || waddr_reg[7:2] == `REG_JUST_CNT_OFS >> 2)
        begin
          bresp_reg <= `RESP_OKAY;
        end
      end
      if (bvalid_reg && bready)
      begin
        bvalid_reg  <= 1'b0;
        awready_reg <= 1'b1;
        wready_reg  <= 1'b1;
      end
      if (arvalid && arready_reg)
      begin
        arready_reg <= 1'b0;
        rvalid_reg  <= 1'b1;
        rresp_reg   <= `RESP_OKAY;
        rdata_reg   <= 32'h00000000;
        case (araddr[7:2])
          `REG_CTRL_OFS >> 2:
            rdata_reg <= ctrl_reg;
          `REG_STATUS_OFS >> 2:
          begin
            rdata_reg[`STAT_PTR_LSB+9:`STAT_PTR_LSB] <= ptr_reg;
            rdata_reg[`STAT_FILL_LSB+ADDR_W:`STAT_FILL_LSB] <= fill;
            rdata_reg[`STAT_EMPTY_BIT] <= empty;
            rdata_reg[`STAT_ALARM_BIT] <= alarm_insert_action;
            rdata_reg[`STAT_PHASE_LSB+1:`STAT_PHASE_LSB] <= phase_reg;
          end
          `REG_JUST_CNT_OFS >> 2:
            rdata_reg <= {neg_cnt_reg, pos_cnt_reg};
          default:
            rresp_reg <= `RESP_SLVERR;
        endcase
      end
      if (rvalid_reg && rready)
      begin
        rvalid_reg  <= 1'b0;
        arready_reg <= 1'b1;
      end
    end
  end

  assign group_access_data_out        = data_out_reg;
  assign group_access_data_oe         = oe_reg;
  assign group_access_clock_out       = clk_out_reg;
  assign group_access_frame_start_out = fs_out_reg;
  assign awready = awready_reg;
  assign wready  = wready_reg;
  assign bresp   = bresp_reg;
  assign bvalid  = bvalid_reg;
  assign arready = arready_reg;
  assign rdata   = rdata_reg;
  assign rresp   = rresp_reg;
  assign rvalid  = rvalid_reg;

endmodule // tu_pointer_adaptation_source

`default_nettype wire

/* File: test/tb_tu_pointer_adaptation_source.sv */
`timescale 1ns/1ps
`default_nettype none
`include "tu_adapt_defs.vh"
module tb_tu_pointer_adaptation_source;
  logic        sys_clk, sys_rst, act, ssf, trib_en;
  logic        tck, tfs, ack, afs, amfs;
  logic [7:0]  tdat, awaddr, araddr, dout;
  logic        awvalid, wvalid, bready, arvalid, rready;
  logic [31:0] wdata, rdata, rd;
  logic        awready, wready, bvalid, arready, rvalid, oe, cko, fso;
  logic [1:0]  bresp, rresp, rsp;
  logic [15:0] pos, dif;
  logic [31:0] cfg [6] = '{32'h00011401, 32'h00011501, 32'h00010100,
                           32'h00031400, 32'h00000500, 32'h00020700};
  int          fail_count, total_checks, cyc, i;
  // The bench is the only source on the access point, so no slot is shared.
  tu_pointer_adaptation_source tu_pointer_adaptation_source_inst
  (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .tributary_data_in(tdat),
    .tributary_clock_in(tck), .tributary_frame_start_in(tfs),
    .server_fail_in(ssf), .aggregate_clock_in(ack),
    .aggregate_frame_start_in(afs), .aggregate_multiframe_start_in(amfs),
    .activate_ctrl(act), .group_access_data_out(dout),
    .group_access_data_oe(oe), .group_access_clock_out(cko),
    .group_access_frame_start_out(fso), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hF),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready)
  );
  tu_link_model tu_link_model_inst
  (
    .trib_en(trib_en), .trib_clk(tck), .trib_data(tdat), .trib_fs(tfs),
    .agg_clk(ack), .agg_fs(afs), .agg_mfs(amfs)
  );
  initial
  begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  task automatic fail_msg(input logic [31:0] got, exp);
    fail_count++;
    $display("mismatch at %0t: got %h expected %h", $time, got, exp);
  endtask
  task automatic chk_word(input logic [31:0] got, exp);
    total_checks++;
    if (got !== exp)
      fail_msg(got, exp);
  endtask
  task automatic chk_resp(input logic [1:0] got, exp);
    total_checks++;
    if (got !== exp)
      fail_msg({30'h0, got}, {30'h0, exp});
  endtask
  task automatic chk_bit(input logic got, exp);
    total_checks++;
    if (got !== exp)
      fail_msg({31'h0, got}, {31'h0, exp});
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge sys_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 90000)
    begin
      fail_count++;
      report_and_stop();
    end
  end
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    fork
      begin
        do @(posedge sys_clk); while (awready !== 1'b1);
        awvalid <= 1'b0;
      end
      begin
        do @(posedge sys_clk); while (wready !== 1'b1);
        wvalid <= 1'b0;
      end
    join
    // Ready comes late on purpose, so that a held response is exercised.
    repeat (2) @(posedge sys_clk);
    bready <= 1'b1;
    do @(posedge sys_clk); while (bvalid !== 1'b1);
    rsp = bresp;
    bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a);
    @(posedge sys_clk);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge sys_clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    @(posedge sys_clk);
    rready <= 1'b1;
    do @(posedge sys_clk); while (rvalid !== 1'b1);
    rd = rdata;
    rsp = rresp;
    rready <= 1'b0;
  endtask
  // Waits until the decision of the V1 frame has been taken.
  task automatic wait_mf();
    @(posedge amfs);
    repeat (20) @(posedge sys_clk);
  endtask
  // Checks one whole V1 frame, slot by slot, once each output has settled.
  task automatic scan(input logic tu2, input int l, m, input logic a, ais);
    int  s;
    int  b;
    logic own;
    @(posedge amfs);
    for (s = 0; s < 60; s++)
    begin
      @(posedge ack);
      repeat (6) @(posedge sys_clk);
      #1;
      b = 3 * (l - 1) + (tu2 ? 0 : m - 1);
      own = a && l >= 1 && l <= 20 &&
            (tu2 ? (s >= b && s < b + 3) : (m >= 1 && m <= 3 && s == b));
      chk_bit(oe, own);
      chk_bit(fso, a && s == 0);
      if (own && ais)
        chk_word({24'h0, dout}, 32'hFF);
      else if (own && s == b)
      begin
        chk_resp(dout[3:2], tu2 ? `SS_TU2 : `SS_TU12);
        chk_bit(dout[7:4] === `NDF_NORMAL || dout[7:4] === `NDF_NEW,
                1'b1);
      end
    end
  endtask
  initial
  begin
    {sys_rst, act, ssf, trib_en} = 4'h8;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    {awaddr, araddr, wdata, fail_count, total_checks, cyc} = '0;
    repeat (16) @(posedge sys_clk);
    sys_rst <= 1'b0;
    axi_rd(`REG_CTRL_OFS);
    chk_word(rd, `CTRL_RESET);
    axi_rd(8'h0C);
    chk_resp(rsp, `RESP_SLVERR);
    chk_word(rd, 32'h0);
    axi_wr(8'h10, 32'h0);
    chk_resp(rsp, `RESP_SLVERR);
    axi_wr(`REG_STATUS_OFS, 32'hFFFFFFFF);
    chk_resp(rsp, `RESP_OKAY);
    scan(1'b1, 1, 1, 1'b0, 1'b0);
    act <= 1'b1;
    wait_mf();
    axi_rd(`REG_JUST_CNT_OFS);
    pos = rd[15:0];
    repeat (3) wait_mf();
    axi_rd(`REG_JUST_CNT_OFS);
    dif = rd[15:0] - pos;
    chk_word({16'h0, dif}, 32'h3);
    axi_rd(`REG_STATUS_OFS);
    chk_bit(rd[`STAT_EMPTY_BIT], 1'b1);
    scan(1'b1, 1, 1, 1'b1, 1'b0);
    trib_en <= 1'b1;
    for (i = 0; i < 6; i++)
    begin
      axi_wr(`REG_CTRL_OFS, 32'h00100000 | cfg[i]);
      scan(cfg[i][0], cfg[i][12:8], cfg[i][17:16], 1'b1, 1'b0);
    end
    ssf <= 1'b1;
    scan(1'b0, 7, 2, 1'b1, 1'b1);
    axi_rd(`REG_STATUS_OFS);
    chk_bit(rd[`STAT_ALARM_BIT], 1'b1);
    ssf <= 1'b0;
    scan(1'b0, 7, 2, 1'b1, 1'b0);
    axi_wr(`REG_CTRL_OFS, 32'h00020700);
    ssf <= 1'b1;
    scan(1'b0, 7, 2, 1'b1, 1'b0);
    axi_rd(`REG_JUST_CNT_OFS);
    chk_bit(rd[31:16] != 16'h0, 1'b1);
    axi_rd(`REG_STATUS_OFS);
    chk_bit(rd[`STAT_EMPTY_BIT], 1'b0);
    chk_bit(rd[20:16] > 5'd12, 1'b1);
    act <= 1'b0;
    scan(1'b0, 7, 2, 1'b0, 1'b0);
    report_and_stop();
  end
endmodule // tb_tu_pointer_adaptation_source
`default_nettype wire

/* File: test/tu_adapt_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module tu_adapt_properties
(
  input wire logic        sys_clk,
  input wire logic        sys_rst,
  input wire logic        activate_ctrl,
  input wire logic [7:0]  group_access_data_out,
  input wire logic        group_access_data_oe,
  input wire logic        group_access_clock_out,
  input wire logic        group_access_frame_start_out,
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic [1:0]  bresp,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic [31:0] rdata,
  input wire logic        rvalid,
  input wire logic        rready
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  logic [2:0] idle_cnt;
  // Counts cycles with activation low, so the sync delay is allowed for.
  always @(posedge sys_clk)
    if (sys_rst || activate_ctrl)
      idle_cnt <= 3'h0;
    else if (idle_cnt != 3'h7)
      idle_cnt <= idle_cnt + 3'h1;
  sequence wr_taken;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence rd_taken;
    arvalid && arready;
  endsequence
  inactive_quiet_a:
    assert property (idle_cnt >= 3'h5 |-> !group_access_data_oe &&
      !group_access_clock_out && !group_access_frame_start_out &&
      group_access_data_out == 8'h00)
    else $error("access point driven while inactive");
  frame_mark_a:
    assert property ($rose(group_access_frame_start_out) |->
      ##[1:8] $fell(group_access_frame_start_out))
    else $error("frame start output longer than one slot");
  clk_high_max_a:
    assert property (group_access_clock_out [*4] |=>
      !group_access_clock_out)
    else $error("clock output high too long");
  clk_low_min_a:
    assert property ($fell(group_access_clock_out) |->
      !group_access_clock_out [*4])
    else $error("clock output low too short");
  write_answer_a:
    assert property (wr_taken |-> ##2 bvalid)
    else $error("write response late");
  aw_busy_a:
    assert property (wr_taken |=> !awready && !wready)
    else $error("write accepted while busy");
  bresp_hold_a:
    assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");
  read_answer_a:
    assert property (rd_taken |=> rvalid && !arready)
    else $error("read data late");
  rdata_hold_a:
    assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped");
endmodule // tu_adapt_properties
bind tu_pointer_adaptation_source tu_adapt_properties tu_adapt_properties_inst
(
  .sys_clk(sys_clk), .sys_rst(sys_rst), .activate_ctrl(activate_ctrl),
  .group_access_data_out(group_access_data_out),
  .group_access_data_oe(group_access_data_oe),
  .group_access_clock_out(group_access_clock_out),
  .group_access_frame_start_out(group_access_frame_start_out),
  .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready),
  .bresp(bresp), .bvalid(bvalid), .bready(bready), .arvalid(arvalid),
  .arready(arready), .rdata(rdata), .rvalid(rvalid), .rready(rready)
);
`default_nettype wire

/* File: test/tu_link_model.sv */
`timescale 1ns/1ps
`default_nettype none
module tu_link_model
(
  input  wire logic  trib_en,
  output logic       trib_clk,
  output logic [7:0] trib_data,
  output logic       trib_fs,
  output logic       agg_clk,
  output logic       agg_fs,
  output logic       agg_mfs
);
  int tcnt;
  int slot;
  int frame;
  // The tributary clock stands still while disabled; data keeps changing.
  initial
  begin
    trib_clk = 1'b0;
    trib_data = 8'h00;
    trib_fs = 1'b0;
    tcnt = 0;
    #137;
    forever
    begin
      #200;
      trib_clk = 1'b0;
      tcnt = (tcnt + 1) % 140;
      trib_fs = (tcnt == 0);
      trib_data = trib_data + 8'h01;
      #200;
      trib_clk = trib_en;
    end
  end
  // Markers change mid-byte, away from the rising edge that samples them.
  initial
  begin
    agg_clk = 1'b0;
    agg_fs = 1'b0;
    agg_mfs = 1'b0;
    slot = 59;
    frame = 3;
    #13;
    forever
    begin
      #200;
      agg_clk = 1'b0;
      slot = (slot + 1) % 60;
      if (slot == 0)
        frame = (frame + 1) % 4;
      agg_fs = (slot == 0);
      agg_mfs = (slot == 0) && (frame == 0);
      #200;
      agg_clk = 1'b1;
    end
  end
endmodule // tu_link_model
`default_nettype wire
